// ===== hdl/pfcs_map.svh
// Constants of the frequency configuration select block.
`ifndef PFCS_MAP_SVH
`define PFCS_MAP_SVH
`define PFCS_NUM_SETS       4
`define PFCS_SEL_REG_ADDR   5'h12
`define PFCS_SEL_LSB        3
`define PFCS_SEL_MSB        4
`define PFCS_BYP_BIT        5
`define PFCS_CONV_BIT       7
`define PFCS_PRE_RST        2'h0
`define PFCS_INT_RST        7'h15
`define PFCS_FRAC_RST       18'h38023
`define PFCS_POST_RST       7'h04
`define PFCS_CAL_TIME_NS    100
`define PFCS_CLK_NS         5
`define PFCS_CAL_CYC        ((`PFCS_CAL_TIME_NS + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
`endif

// ===== hdl/pfcs_pkg.sv
// Types of the frequency configuration select block.
package pfcs_pkg;
	typedef struct packed {
		logic [1:0]  pre_div;
		logic [6:0]  fb_int_div;
		logic [17:0] fb_frac_div;
		logic [6:0]  post_div;
	} pfcs_set_t;
	typedef struct packed {
		logic        we;
		logic [1:0]  idx;
		pfcs_set_t   data;
	} pfcs_wr_t;
	typedef enum logic [1:0] {
		PFCS_RUN   = 2'b00,
		PFCS_CAL   = 2'b01,
		PFCS_APPLY = 2'b10
	} pfcs_state_t;
endpackage

// ===== hdl/pfcs_post_decode.sv
// Post divider code decoder to the division ratio.
`timescale 1ns/100ps
module pfcs_post_decode (
	input  wire logic [6:0] post_code,
	output logic      [6:0] post_ratio
);
	always_comb begin
		casez (post_code)
			7'b000000?: post_ratio = 7'h02;
			7'b0000010: post_ratio = 7'h02;
			7'b0000011: post_ratio = 7'h03;
			7'b0000100: post_ratio = 7'h04;
			7'b0000101: post_ratio = 7'h05;
			7'b000011?: post_ratio = 7'h06;
			7'b000100?: post_ratio = 7'h08;
			7'b000101?: post_ratio = 7'h0A;
			default:    post_ratio = {post_code[6:1], 1'b0};
		endcase
	end
endmodule

// ===== hdl/pfcs_top.sv
// Configuration set store, selection and recalibration control.
`timescale 1ns/100ps
`include "pfcs_map.svh"
// Functional notes
// - Four configuration sets; two-bit select picks set 0 to 3.
// - Reset loads factory presets into every set, discarding host writes.
// - Initial active set comes from select input at power-up.
// - Host can read back every configuration set.
// - A select change switches output dividers to the new set.
// - Each set has 2-bit pre-divider and 7-bit post divider.
// - Feedback divider is 7-bit integer plus 18-bit fraction.
// - Effective fraction is field over 2^18 plus 2^-19.
// - Post divider codes decode to ratios 2,3,4,5,6,8,10; codes 12 and up decode to even ratios 12-126.
// - Set count depends on variant: four, two or one.
// - Toggling select field or pins forces PLL recalibration.
// - Output range 15.476-866.67 MHz and 975-1300 MHz supported.
// - Register 18 holds select in bits 4:3, bypass and converter.
module pfcs_top #(
	parameter int NUM_SETS = `PFCS_NUM_SETS
) (
	input  wire logic                core_clk,
	input  wire logic                sys_rst,
	input  wire logic [1:0]          config_select_pin,
	input  wire pfcs_pkg::pfcs_wr_t  set_wr,
	input  wire logic                ctrl_we,
	input  wire logic [7:0]          ctrl_wdata,
	input  wire logic [1:0]          rd_idx,
	output pfcs_pkg::pfcs_set_t      rd_data,
	output logic      [7:0]          ctrl_rdata,
	output pfcs_pkg::pfcs_set_t      active_set,
	output logic      [2:0]          pre_ratio,
	output logic      [6:0]          post_ratio,
	output logic      [18:0]         fb_frac_eff,
	output logic      [1:0]          active_idx,
	output logic                     recal,
	output logic                     synth_bypass_n,
	output logic                     converter_enable
);
	pfcs_pkg::pfcs_set_t   sets [0:3];
	pfcs_pkg::pfcs_set_t   next_sets [0:3];
	pfcs_pkg::pfcs_state_t state;
	pfcs_pkg::pfcs_state_t next_state;
	logic [1:0] pin_q;
	logic [1:0] next_pin_q;
	logic [1:0] config_select;
	logic [1:0] next_config_select;
	logic       started;
	logic [7:0] cal_cnt;
	logic [7:0] next_cal_cnt;
	logic [1:0] next_active_idx;
	logic       next_bypass_n;
	logic       next_conv;
	logic       sel_change;
	logic [1:0] req_idx;
	logic [6:0] dec_ratio;
	logic       pin_chg;
	logic       next_started;
	pfcs_pkg::pfcs_set_t   next_rd_data;
	logic [7:0]            next_ctrl_rdata;
	pfcs_pkg::pfcs_set_t   next_active_set;
	logic [2:0]            next_pre_ratio;
	logic [6:0]            next_post_ratio;
	logic [18:0]           next_fb_frac_eff;
	logic                  next_recal;

	// Sets beyond the variant count alias down onto set 0 or 1.
	function automatic logic [1:0] pfcs_clip(input logic [1:0] idx);
		pfcs_clip = (NUM_SETS == 1) ? 2'h0 :
			(NUM_SETS == 2) ? {1'b0, idx[0]} : idx;
	endfunction

	function automatic logic [2:0] pfcs_pre(input logic [1:0] code);
		case (code)
			2'b00:   pfcs_pre = 3'h1;
			2'b01:   pfcs_pre = 3'h2;
			2'b10:   pfcs_pre = 3'h4;
			default: pfcs_pre = 3'h5;
		endcase
	endfunction

	pfcs_post_decode u_post (
		.post_code  (sets[active_idx].post_div),
		.post_ratio (dec_ratio)
	);

	// A pin change and a register field change are one event. A pin toggle
	// recalibrates even when it lands on the set that is already chosen.
	always_comb begin
		next_pin_q = config_select_pin;
		next_started = 1'b1;
		pin_chg = (config_select_pin != pin_q);
		next_config_select = config_select;
		if (!started) begin
			next_config_select = config_select_pin;
		end else if (ctrl_we) begin
			next_config_select = ctrl_wdata[`PFCS_SEL_MSB:`PFCS_SEL_LSB];
		end else if (pin_chg) begin
			next_config_select = config_select_pin;
		end
		sel_change = started && (ctrl_we || pin_chg);
		req_idx = pfcs_clip(next_config_select);
	end

	always_comb begin
		next_state = state;
		next_cal_cnt = cal_cnt;
		next_active_idx = active_idx;
		if (!started) begin
			next_active_idx = req_idx;
		end
		case (state)
			pfcs_pkg::PFCS_RUN: begin
				if (sel_change) begin
					next_state = pfcs_pkg::PFCS_CAL;
					next_cal_cnt = 8'(`PFCS_CAL_CYC);
					next_active_idx = req_idx;
				end
			end
			pfcs_pkg::PFCS_CAL: begin
				if (sel_change) begin
					next_cal_cnt = 8'(`PFCS_CAL_CYC);
					next_active_idx = req_idx;
				end else if (cal_cnt == 8'h01) begin
					next_state = pfcs_pkg::PFCS_APPLY;
				end else begin
					next_cal_cnt = cal_cnt - 8'h01;
				end
			end
			pfcs_pkg::PFCS_APPLY: begin
				if (sel_change) begin
					next_state = pfcs_pkg::PFCS_CAL;
					next_cal_cnt = 8'(`PFCS_CAL_CYC);
					next_active_idx = req_idx;
				end else begin
					next_state = pfcs_pkg::PFCS_RUN;
				end
			end
			default: begin
				next_state = pfcs_pkg::PFCS_RUN;
			end
		endcase
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			next_sets[i] = sets[i];
		end
		// Writes to the active set are accepted but disturb the output.
		if (set_wr.we) begin
			next_sets[pfcs_clip(set_wr.idx)] = set_wr.data;
		end
		next_bypass_n = synth_bypass_n;
		next_conv = converter_enable;
		if (ctrl_we) begin
			next_bypass_n = ctrl_wdata[`PFCS_BYP_BIT];
			next_conv = ctrl_wdata[`PFCS_CONV_BIT];
		end
	end

	// Every output is a registered copy, so a decoded ratio trails the
	// active index by one clock.
	always_comb begin
		next_rd_data = sets[pfcs_clip(rd_idx)];
		next_ctrl_rdata = {converter_enable, 1'b0, synth_bypass_n,
			config_select, 3'h0};
		next_active_set = sets[active_idx];
		next_pre_ratio = pfcs_pre(sets[active_idx].pre_div);
		next_post_ratio = dec_ratio;
		next_fb_frac_eff = {sets[active_idx].fb_frac_div, 1'b1};
		next_recal = (next_state == pfcs_pkg::PFCS_CAL);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 4; i++) begin
				sets[i] <= '{`PFCS_PRE_RST, `PFCS_INT_RST,
					`PFCS_FRAC_RST, `PFCS_POST_RST};
			end
			state <= pfcs_pkg::PFCS_RUN;
			cal_cnt <= 8'h00;
			started <= 1'b0;
			pin_q <= 2'h0;
			config_select <= 2'h0;
			active_idx <= 2'h0;
			synth_bypass_n <= 1'b1;
			converter_enable <= 1'b0;
		end else begin
			sets <= next_sets;
			state <= next_state;
			cal_cnt <= next_cal_cnt;
			started <= next_started;
			pin_q <= next_pin_q;
			synth_bypass_n <= next_bypass_n;
			converter_enable <= next_conv;
			config_select <= next_config_select;
			active_idx <= next_active_idx;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_data <= '0;
			ctrl_rdata <= 8'h00;
			active_set <= '0;
			pre_ratio <= 3'h1;
			post_ratio <= 7'h02;
			fb_frac_eff <= 19'h00001;
			recal <= 1'b0;
		end else begin
			rd_data <= next_rd_data;
			ctrl_rdata <= next_ctrl_rdata;
			active_set <= next_active_set;
			pre_ratio <= next_pre_ratio;
			post_ratio <= next_post_ratio;
			fb_frac_eff <= next_fb_frac_eff;
			recal <= next_recal;
		end
	end
endmodule

// ===== tb/pfcs_top_monitor.sv
// Port assertions of the frequency configuration select block.
`timescale 1ns/100ps
module pfcs_top_monitor #(parameter int NUM_SETS = 4) (
	input wire logic                core_clk,
	input wire logic                sys_rst,
	input wire logic [1:0]          config_select_pin,
	input wire logic                ctrl_we,
	input wire logic [7:0]          ctrl_wdata,
	input wire logic [7:0]          ctrl_rdata,
	input wire pfcs_pkg::pfcs_set_t active_set,
	input wire logic [2:0]          pre_ratio,
	input wire logic [18:0]         fb_frac_eff,
	input wire logic [1:0]          active_idx,
	input wire logic                recal,
	input wire logic                synth_bypass_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	AST_PIN_RECAL:
		assert property ($changed(config_select_pin) |=> recal)
		else $error("no recal after pin change");
	AST_PIN_IDX:
		assert property ($changed(config_select_pin) && !ctrl_we |=>
			active_idx == ($past(config_select_pin) & 2'(NUM_SETS - 1)))
		else $error("active index does not follow pins");
	AST_CAL_LEN:
		assert property ($fell(recal) && !$past(sys_rst) |-> $past(recal, 20))
		else $error("recal shorter than calibration time");
	AST_FRAC:
		assert property (fb_frac_eff == {active_set.fb_frac_div, 1'b1})
		else $error("fraction lacks half step");
	AST_PRE:
		assert property (pre_ratio == (active_set.pre_div == 2'h3 ? 3'h5 :
			3'h1 << active_set.pre_div))
		else $error("pre ratio wrong");
	AST_RST:
		assert property ($fell(sys_rst) |-> !recal && active_idx == 2'h0 &&
			fb_frac_eff == 19'h1)
		else $error("outputs not at reset values");
	AST_CTRL:
		assert property (ctrl_we |=> recal && synth_bypass_n ==
			$past(ctrl_wdata[5]) && active_idx ==
			($past(ctrl_wdata[4:3]) & 2'(NUM_SETS - 1)))
		else $error("control write not applied");
	AST_CTRL_RD:
		assert property (ctrl_we |-> ##2 (ctrl_rdata & 8'hE7) ==
			($past(ctrl_wdata, 2) & 8'hA0))
		else $error("control readback wrong");
	cover property ($fell(recal));
	cover property (ctrl_we ##2 recal);
	cover property ($changed(config_select_pin) ##1 recal);
endmodule
bind pfcs_top pfcs_top_monitor #(.NUM_SETS(NUM_SETS)) mon_u (.*);

// ===== tb/pfcs_host_model.sv
// Host model: programs configuration sets and drives the select pins.
`timescale 1ns/100ps
module pfcs_host_model (
	output pfcs_pkg::pfcs_wr_t set_wr,
	output logic [1:0]         config_select_pin,
	output logic               ctrl_we,
	output logic [7:0]         ctrl_wdata,
	input  wire logic          core_clk
);
	initial {set_wr, config_select_pin, ctrl_we, ctrl_wdata} = '0;
	// Callers only target a set that is not active at the time.
	task automatic write_set(input logic [1:0] idx,
		input pfcs_pkg::pfcs_set_t v);
		@(posedge core_clk);
		set_wr <= {1'b1, idx, v};
		@(posedge core_clk);
		set_wr.we <= 1'b0;
	endtask
	// Every reprogramming is followed by a select change for recalibration.
	task automatic sel(input logic [1:0] v);
		@(posedge core_clk);
		config_select_pin <= v;
	endtask
	task automatic ctrl(input logic cv, input logic byp, input logic [1:0] v);
		@(posedge core_clk);
		ctrl_wdata <= {cv, 1'b0, byp, v, 3'h0};
		ctrl_we <= 1'b1;
		@(posedge core_clk);
		ctrl_we <= 1'b0;
	endtask
endmodule

// ===== tb/pfcs_top_tb.sv
// Self-checking bench of the frequency configuration select block.
`timescale 1ns/100ps
`include "pfcs_map.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
	$display("unexpected %s exp %h got %h", n, e, g); num_errors++; end end
module pfcs_top_tb;
	logic                core_clk, sys_rst, ctrl_we, recal;
	logic                synth_bypass_n, converter_enable;
	logic [1:0]          config_select_pin, rd_idx, active_idx;
	logic [7:0]          ctrl_wdata, ctrl_rdata;
	logic [2:0]          pre_ratio;
	logic [6:0]          post_ratio;
	logic [18:0]         fb_frac_eff;
	pfcs_pkg::pfcs_wr_t  set_wr;
	pfcs_pkg::pfcs_set_t rd_data, active_set, s, prev;
	pfcs_pkg::pfcs_set_t preset = '{`PFCS_PRE_RST, `PFCS_INT_RST,
		`PFCS_FRAC_RST, `PFCS_POST_RST};
	logic [6:0]          pc[8] = '{7'h00, 7'h03, 7'h04, 7'h05,
		7'h07, 7'h08, 7'h0B, 7'h02};
	logic [6:0]          pr[8] = '{7'h02, 7'h03, 7'h04, 7'h05,
		7'h06, 7'h08, 7'h0A, 7'h02};
	// Integer parts keep the oscillator near 2500 MHz for each pre-divider.
	logic [6:0]          fi[4] = '{7'h15, 7'h2B, 7'h57, 7'h6D};
	int                  num_errors, checks, cycles;
	pfcs_top dut_u (.*);
	pfcs_host_model host_u (.*);
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic final_report();
		if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			final_report();
		end
	end
	initial begin
		sys_rst = 1'b1;
		rd_idx = 2'h0;
		prev = preset;
		host_u.sel(2'h2);
		repeat (7) @(posedge core_clk);
		sys_rst <= 1'b0;
		tick(3);
		`CHK("idx", 2'h2, active_idx)
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk) rd_idx <= i[1:0];
			tick(1);
			`CHK("preset", preset, rd_data)
		end
		// Alternate sets 0 and 1 so the written set is never the active one.
		for (int i = 0; i < 8; i++) begin
			s = '{i[1:0], fi[i[1:0]], 18'h38023 + 18'(i), pc[i]};
			host_u.write_set({1'b0, i[0]}, s);
			tick(0);
			`CHK("inactive", prev, active_set)
			host_u.sel({1'b0, i[0]});
			@(posedge core_clk) rd_idx <= {1'b0, i[0]};
			tick(1);
			`CHK("recal", 1'b1, recal)
			`CHK("set", s, active_set)
			`CHK("readback", s, rd_data)
			`CHK("post", pr[i], post_ratio)
			`CHK("pre", i[1:0] == 2'h3 ? 3'h5 : 3'h1 << i[1:0], pre_ratio)
			`CHK("frac", {s.fb_frac_div, 1'b1}, fb_frac_eff)
			tick(`PFCS_CAL_CYC - 2);
			`CHK("busy", 1'b1, recal)
			tick(1);
			`CHK("done", 1'b0, recal)
			prev = s;
		end
		host_u.ctrl(1'b1, 1'b0, 2'h3);
		tick(2);
		`CHK("ctrl idx", 2'h3, active_idx)
		`CHK("ctrl rd", 8'h98, ctrl_rdata)
		`CHK("ctrl cal", 1'b1, recal)
		`CHK("ctrl bits", 2'h1, {synth_bypass_n, converter_enable})
		tick(`PFCS_CAL_CYC);
		`CHK("ctrl done", 1'b0, recal)
		// The pins now land on the set that the register field chose.
		host_u.sel(2'h3);
		tick(1);
		`CHK("pin recal", 1'b1, recal)
		@(posedge core_clk) sys_rst <= 1'b1;
		tick(2);
		@(posedge core_clk) sys_rst <= 1'b0;
		tick(3);
		`CHK("volatile", preset, rd_data)
		`CHK("rst idx", 2'h3, active_idx)
		final_report();
	end
endmodule
